// ==== core/iac_edge_detect.v ====
// Synchronised edge detector with selectable active transition
`timescale 1ns/1ns
module iac_edge_detect (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Pin and selection
  input wire pin,
  input wire rising_sel,
  // Results
  output wire level,
  output wire active_edge
);
  reg sync_a;
  reg sync_b;
  reg prev;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      prev <= 1'b1;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end

  assign level = sync_b;
  assign active_edge = rising_sel ? (sync_b & ~prev) : (~sync_b & prev);
endmodule // iac_edge_detect

// ==== core/iac_interrupt_ctrl.v ====
// Interrupt flag, enable and request logic of the parallel interface adapter
// Operation
// - External-pulse shift-out shifts only on line 1 pulses; flags each eight, never stops.
// - Any shift register access clears shift flag and restarts the pulse count.
// - Request goes low whenever any flag and its enable are both one.
// - Request is open-collector: pulled low or released, never driven high.
// - Flag bits 6..0: timer 1, timer 2, PB1, PB2, shift, PA1, PA2; bit 7 summary.
// - Flag bit 7 reads OR of each flag ANDed with its enable.
// - Port A line flags set by transitions; cleared by port A output access.
// - Shift flag set on eight shifts; cleared by shift register access.
// - Port B line flags set by transitions; cleared by port B output access.
// - Second timer flag set on timeout; cleared by low read or high write.
// - First timer flag set on timeout; cleared by low read or high write.
// - Writes to flag bit 7 ignored; it falls only when no enabled flag.
// - Flag read returns contents; writing one clears that flag bit.
// - Enable write with bit 7 low clears each enable written as one.
// - Enable write with bit 7 high sets each enable written as one.
// - Enable read returns the seven enables with bit 7 zero.
// - Line control: PB2 in 7..5, PB1 in 4, PA2 in 3..1, PA1 in 0.
// - Port A line 1 edge select: zero falling, one rising.
// - Independent line-2 input modes: only writing one to the flag clears it.
`timescale 1ns/1ns
`include "iac_map.vh"
module iac_interrupt_ctrl (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Register bus
  input wire chip_sel,
  input wire [3:0] reg_sel,
  input wire read_not_write,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  // Peripheral control lines
  input wire port_a_line_1,
  input wire port_a_line_2,
  input wire port_b_line_1,
  input wire port_b_line_2,
  // Timer events from the timer blocks
  input wire first_timer_timeout,
  input wire second_timer_timeout,
  // Shift register serial output
  output wire shift_serial_out,
  // Open-collector request
  output wire irq_out,
  output wire irq_oe
);
  reg [7:0] peripheral_line_control;
  reg [2:0] shf_mode;
  reg [6:0] flags;
  reg [6:0] enables;
  reg [6:0] next_flags;
  reg [7:0] next_data_out;
  wire pa1_level;
  wire pa1_edge;
  wire pa2_level;
  wire pa2_edge;
  wire pb1_level;
  wire pb1_edge;
  wire pb2_level;
  wire pb2_edge;
  wire [7:0] shift_data;
  wire shift_done;
  wire summary;

  // Mode of a line-2 pin, 3-bit field
  function is_independent_input;
    input [2:0] fld;
    begin
      is_independent_input = (fld[2] == 1'b0) && fld[0];
    end
  endfunction

  function is_input;
    input [2:0] fld;
    begin
      is_input = (fld[2] == 1'b0);
    end
  endfunction

  wire access = chip_sel;
  wire wr = chip_sel & ~read_not_write;
  wire rd = chip_sel & read_not_write;
  wire [2:0] pa2_fld = peripheral_line_control[`IAC_LC_PA2_HI:`IAC_LC_PA2_LO];
  wire [2:0] pb2_fld = peripheral_line_control[`IAC_LC_PB2_HI:`IAC_LC_PB2_LO];
  wire acc_pa = access && (reg_sel == `IAC_OFS_PORT_A_OUT);
  wire acc_pb = access && (reg_sel == `IAC_OFS_PORT_B_OUT);
  wire acc_shf = access && (reg_sel == `IAC_OFS_SHIFT);
  wire tmr1_clr = (rd && reg_sel == `IAC_OFS_TMR1_CNT_LO) ||
    (wr && reg_sel == `IAC_OFS_TMR1_CNT_HI);
  wire tmr2_clr = (rd && reg_sel == `IAC_OFS_TMR2_CNT_LO) ||
    (wr && reg_sel == `IAC_OFS_TMR2_CNT_HI);
  wire [6:0] wr_clear = (wr && reg_sel == `IAC_OFS_FLAG) ? data_in[6:0] : 7'h00;

  iac_edge_detect u_pa1 (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin(port_a_line_1),
    .rising_sel(peripheral_line_control[`IAC_LC_PA1_EDGE]),
    .level(pa1_level),
    .active_edge(pa1_edge)
  );

  iac_edge_detect u_pa2 (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin(port_a_line_2),
    .rising_sel(pa2_fld[1]),
    .level(pa2_level),
    .active_edge(pa2_edge)
  );

  iac_edge_detect u_pb1 (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin(port_b_line_1),
    .rising_sel(peripheral_line_control[`IAC_LC_PB1_EDGE]),
    .level(pb1_level),
    .active_edge(pb1_edge)
  );

  iac_edge_detect u_pb2 (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin(port_b_line_2),
    .rising_sel(pb2_fld[1]),
    .level(pb2_level),
    .active_edge(pb2_edge)
  );

  // Shifts on the selected edge of port B line 1
  iac_shift_unit u_shift (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .mode(shf_mode),
    .shift_pulse(pb1_edge),
    .host_access(acc_shf),
    .host_write(wr),
    .host_wdata(data_in),
    .shift_data(shift_data),
    .serial_out(shift_serial_out),
    .done(shift_done)
  );

  // Set wins over any clear in the same cycle, except that disabled shift mode keeps the shift flag clear
  always @* begin
    next_flags = flags & ~wr_clear;
    if (acc_pa) begin
      next_flags[`IAC_BIT_PA1] = 1'b0;
      if (!is_independent_input(pa2_fld))
        next_flags[`IAC_BIT_PA2] = 1'b0;
    end
    if (acc_pb) begin
      next_flags[`IAC_BIT_PB1] = 1'b0;
      if (!is_independent_input(pb2_fld))
        next_flags[`IAC_BIT_PB2] = 1'b0;
    end
    if (acc_shf)
      next_flags[`IAC_BIT_SHIFT] = 1'b0;
    if (tmr1_clr)
      next_flags[`IAC_BIT_TMR1] = 1'b0;
    if (tmr2_clr)
      next_flags[`IAC_BIT_TMR2] = 1'b0;
    if (pa1_edge)
      next_flags[`IAC_BIT_PA1] = 1'b1;
    if (pa2_edge && is_input(pa2_fld))
      next_flags[`IAC_BIT_PA2] = 1'b1;
    if (pb1_edge)
      next_flags[`IAC_BIT_PB1] = 1'b1;
    if (pb2_edge && is_input(pb2_fld))
      next_flags[`IAC_BIT_PB2] = 1'b1;
    if (shift_done)
      next_flags[`IAC_BIT_SHIFT] = 1'b1;
    if (shf_mode == `IAC_SHF_DISABLED)
      next_flags[`IAC_BIT_SHIFT] = 1'b0;
    if (first_timer_timeout)
      next_flags[`IAC_BIT_TMR1] = 1'b1;
    if (second_timer_timeout)
      next_flags[`IAC_BIT_TMR2] = 1'b1;
  end

  assign summary = |(flags & enables);

  always @* begin
    next_data_out = `IAC_RST_BYTE;
    if (reg_sel == `IAC_OFS_FLAG)
      next_data_out = {summary, flags};
    else if (reg_sel == `IAC_OFS_ENABLE)
      next_data_out = {1'b0, enables};
    else if (reg_sel == `IAC_OFS_LINE_CTRL)
      next_data_out = peripheral_line_control;
    else if (reg_sel == `IAC_OFS_SHIFT)
      next_data_out = shift_data;
    else if (reg_sel == `IAC_OFS_AUX_CTRL)
      next_data_out = {3'h0, shf_mode, 2'h0};
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags <= `IAC_RST_FLAGS;
      enables <= `IAC_RST_FLAGS;
      peripheral_line_control <= `IAC_RST_BYTE;
      shf_mode <= `IAC_SHF_DISABLED;
      data_out <= `IAC_RST_BYTE;
    end else begin
      flags <= next_flags;
      if (rd)
        data_out <= next_data_out;
      if (wr && reg_sel == `IAC_OFS_ENABLE) begin
        if (data_in[`IAC_BIT_SUMMARY])
          enables <= enables | data_in[6:0];
        else
          enables <= enables & ~data_in[6:0];
      end
      if (wr && reg_sel == `IAC_OFS_LINE_CTRL)
        peripheral_line_control <= data_in;
      if (wr && reg_sel == `IAC_OFS_AUX_CTRL)
        shf_mode <= data_in[`IAC_AUX_SHF_HI:`IAC_AUX_SHF_LO];
    end
  end

  // Only ever pulls low; a pull-up outside gives the high level
  assign irq_out = 1'b0;
  assign irq_oe = summary;
endmodule // iac_interrupt_ctrl

// ==== core/iac_map.vh ====
// Register offsets, bit positions and reset values of the interrupt control block
`ifndef IAC_MAP_VH
`define IAC_MAP_VH
`define IAC_OFS_PORT_B_OUT 4'h0
`define IAC_OFS_PORT_A_OUT 4'h1
`define IAC_OFS_TMR1_CNT_LO 4'h4
`define IAC_OFS_TMR1_CNT_HI 4'h5
`define IAC_OFS_TMR2_CNT_LO 4'h8
`define IAC_OFS_TMR2_CNT_HI 4'h9
`define IAC_OFS_SHIFT 4'ha
`define IAC_OFS_AUX_CTRL 4'hb
`define IAC_OFS_LINE_CTRL 4'hc
`define IAC_OFS_FLAG 4'hd
`define IAC_OFS_ENABLE 4'he
`define IAC_BIT_PA2 0
`define IAC_BIT_PA1 1
`define IAC_BIT_SHIFT 2
`define IAC_BIT_PB2 3
`define IAC_BIT_PB1 4
`define IAC_BIT_TMR2 5
`define IAC_BIT_TMR1 6
`define IAC_BIT_SUMMARY 7
`define IAC_LC_PA1_EDGE 0
`define IAC_LC_PA2_LO 1
`define IAC_LC_PA2_HI 3
`define IAC_LC_PB1_EDGE 4
`define IAC_LC_PB2_LO 5
`define IAC_LC_PB2_HI 7
`define IAC_AUX_SHF_LO 2
`define IAC_AUX_SHF_HI 4
`define IAC_SHF_EXT_OUT 3'h7
`define IAC_SHF_DISABLED 3'h0
`define IAC_SHIFT_COUNT 4'h8
`define IAC_RST_BYTE 8'h00
`define IAC_RST_FLAGS 7'h00
`endif

// ==== core/iac_shift_unit.v ====
// Shift register with external-pulse shift-out and eight-pulse counter
`timescale 1ns/1ns
`include "iac_map.vh"
module iac_shift_unit (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Mode and controls
  input wire [2:0] mode,
  input wire shift_pulse,
  input wire host_access,
  input wire host_write,
  input wire [7:0] host_wdata,
  // Results
  output reg [7:0] shift_data,
  output wire serial_out,
  output reg done
);
  reg [3:0] count;
  wire ext_out = (mode == `IAC_SHF_EXT_OUT);

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_data <= `IAC_RST_BYTE;
      count <= 4'h0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (host_access) begin
        // Restarts the count of the next eight pulses
        count <= 4'h0;
        if (host_write)
          shift_data <= host_wdata;
      end else if (ext_out && shift_pulse) begin
        // Bit 7 recirculates so shifting never stops
        shift_data <= {shift_data[6:0], shift_data[7]};
        if (count == `IAC_SHIFT_COUNT - 4'h1) begin
          count <= 4'h0;
          done <= 1'b1;
        end else begin
          count <= count + 4'h1;
        end
      end
    end
  end

  assign serial_out = shift_data[7];
endmodule // iac_shift_unit

// ==== sim/iac_chk_sva.sv ====
// Port checker for the interrupt control block
`timescale 1ns/1ns
module iac_chk (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Register bus
  input wire chip_sel,
  input wire [3:0] reg_sel,
  input wire read_not_write,
  input wire [7:0] data_in,
  input wire [7:0] data_out,
  // Events and request
  input wire first_timer_timeout,
  input wire second_timer_timeout,
  input wire irq_out,
  input wire irq_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire rd = chip_sel && read_not_write;
  wire wr = chip_sel && !read_not_write;
  AST_OC: assert property (irq_out == 1'b0)
    else $error("request pin driven high");
  AST_RST: assert property ($past(sys_rst) |-> !irq_oe)
    else $error("request active after reset");
  AST_SUM: assert property (
    rd && reg_sel == 4'hd |=> data_out[7] == $past(irq_oe))
    else $error("summary bit differs from request");
  AST_ENRD: assert property (rd && reg_sel == 4'he |=> data_out[7] == 1'b0)
    else $error("enable bit 7 not zero");
  AST_ENCLR: assert property (
    wr && reg_sel == 4'he && data_in == 8'h7f |=> !irq_oe)
    else $error("request with all enables cleared");
  AST_T1: assert property (
    wr && reg_sel == 4'he && data_in[7] && data_in[6] ##1
    first_timer_timeout && !chip_sel |=> irq_oe)
    else $error("first timer timeout gave no request");
  AST_T2: assert property (
    wr && reg_sel == 4'he && data_in[7] && data_in[5] ##1
    second_timer_timeout && !chip_sel |=> irq_oe)
    else $error("second timer timeout gave no request");
  AST_HOLD: assert property (!rd |=> $stable(data_out))
    else $error("read data changed without read");
  AST_FLGWR: assert property (
    wr && reg_sel == 4'hd && data_in == 8'hff && !first_timer_timeout
    && !second_timer_timeout |=> !irq_oe)
    else $error("request after all flags cleared");
endmodule // iac_chk

bind iac_interrupt_ctrl iac_chk u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .chip_sel(chip_sel), .reg_sel(reg_sel),
  .read_not_write(read_not_write), .data_in(data_in), .data_out(data_out),
  .first_timer_timeout(first_timer_timeout), .second_timer_timeout(second_timer_timeout),
  .irq_out(irq_out), .irq_oe(irq_oe)
);

// ==== sim/iac_host.sv ====
// Host processor model on the register bus
`timescale 1ns/1ns
module iac_host (
  // Clock
  input wire core_clk,
  // Register bus
  output logic chip_sel,
  output logic [3:0] reg_sel,
  output logic read_not_write,
  output logic [7:0] data_in,
  input wire [7:0] data_out
);
  initial begin
    chip_sel = 1'b0;
    reg_sel = 4'h0;
    read_not_write = 1'b1;
    data_in = 8'h00;
  end
  // Held across the taking edge; data lines inverted once released
  task acc(input logic rw, input logic [3:0] a, input logic [7:0] v, output logic [7:0] rdat);
    @(negedge core_clk);
    chip_sel = 1'b1;
    reg_sel = a;
    read_not_write = rw;
    data_in = v;
    @(negedge core_clk);
    rdat = data_out;
    chip_sel = 1'b0;
    data_in = ~data_in;
  endtask
endmodule // iac_host

// ==== sim/iac_interrupt_ctrl_bench.sv ====
// Self-checking bench for the interrupt control block
`timescale 1ns/1ns
module iac_interrupt_ctrl_bench;
  logic core_clk, sys_rst, pa1, pa2, pb1, pb2, tmo1, tmo2;
  wire cs, rnw, so, irq_out, irq_oe;
  wire [3:0] rs;
  wire [7:0] din, dout;
  logic [7:0] q, d;
  logic [6:0] fl, en;
  int miscompares, tests_run;
  iac_host h (.core_clk(core_clk), .chip_sel(cs), .reg_sel(rs), .read_not_write(rnw),
    .data_in(din), .data_out(dout));
  iac_interrupt_ctrl dut (.core_clk(core_clk), .sys_rst(sys_rst), .chip_sel(cs),
    .reg_sel(rs), .read_not_write(rnw), .data_in(din), .data_out(dout),
    .port_a_line_1(pa1), .port_a_line_2(pa2), .port_b_line_1(pb1), .port_b_line_2(pb2),
    .first_timer_timeout(tmo1), .second_timer_timeout(tmo2), .shift_serial_out(so),
    .irq_out(irq_out), .irq_oe(irq_oe));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #3000000;
    miscompares++;
    stop_test();
  end
  task ck(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task w(input logic [3:0] a, input logic [7:0] v);
    h.acc(1'b0, a, v, q);
  endtask
  task r(input logic [3:0] a);
    h.acc(1'b1, a, 8'h00, q);
  endtask
  task nw(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // One-cycle timeout pulse: 1 first timer, 0 second
  task p(input logic s);
    tmo1 = s;
    tmo2 = !s;
    @(negedge core_clk);
    tmo1 = 1'b0;
    tmo2 = 1'b0;
  endtask
  task rf;
    r(4'hd);
    ck(q, {|(fl & en), fl});
    ck({7'h0, irq_oe}, {7'h0, |(fl & en)});
  endtask
  initial begin
    {sys_rst, pa1, pa2, pb1, pb2} = 5'h1f;
    {tmo1, tmo2, fl, en} = 16'h0;
    {miscompares, tests_run} = 0;
    void'($urandom(90));
    nw(8);
    sys_rst = 1'b0;
    rf();
    r(4'he);
    ck(q, 8'h00);
    $display("test reset done");
    repeat (6) begin
      d = $urandom;
      w(4'he, d | 8'h80);
      en = en | d[6:0];
      w(4'he, {1'b0, d[6:0] ^ 7'h55});
      en = en & ~(d[6:0] ^ 7'h55);
      r(4'he);
      ck(q, {1'b0, en});
    end
    w(4'he, 8'h7f);
    en = 7'h00;
    $display("test enables done");
    for (int i = 0; i < 4; i++) begin
      w(4'he, i[0] ? 8'hc0 : 8'ha0);
      en = en | (i[0] ? 7'h40 : 7'h20);
      p(i[0]);
      fl = fl | (i[0] ? 7'h40 : 7'h20);
      rf();
      h.acc(i < 2, (i[0] ? 4'h4 : 4'h8) + {3'h0, i > 1}, 8'h00, q);
      fl = fl & ~(i[0] ? 7'h40 : 7'h20);
      rf();
    end
    w(4'he, 8'hff);
    en = 7'h7f;
    p(1'b1);
    p(1'b0);
    fl = 7'h60;
    w(4'hd, 8'h40);
    fl = 7'h20;
    rf();
    w(4'hd, 8'hff);
    fl = 7'h00;
    rf();
    $display("test timers done");
    w(4'hc, 8'h01);
    {pa1, pa2, pb1, pb2} = 4'h0;
    nw(5);
    fl = 7'h19;
    rf();
    pa1 = 1'b1;
    nw(5);
    fl = 7'h1b;
    rf();
    r(4'h1);
    fl = 7'h18;
    rf();
    w(4'h0, 8'h00);
    fl = 7'h00;
    rf();
    w(4'hc, 8'h03);
    pa2 = 1'b1;
    nw(5);
    pa2 = 1'b0;
    nw(5);
    fl = 7'h01;
    r(4'h1);
    rf();
    w(4'hd, 8'h01);
    fl = 7'h00;
    rf();
    $display("test lines done");
    w(4'hb, 8'h1c);
    d = $urandom;
    w(4'ha, d);
    repeat (2) begin
      for (int k = 1; k < 9; k++) begin
        pb1 = 1'b1;
        nw(4);
        pb1 = 1'b0;
        nw(4);
        fl = fl | (k == 8 ? 7'h14 : 7'h10);
        ck({7'h0, so}, {7'h0, d[(7 - k) & 7]});
        rf();
      end
      r(4'ha);
      ck(q, d);
      fl[2] = 1'b0;
      rf();
    end
    $display("test shift done");
    d = $urandom;
    w(4'hc, d);
    r(4'hc);
    ck(q, d);
    $display("test control done");
    stop_test();
  end
endmodule // iac_interrupt_ctrl_bench
